// ==== logic/i2c_bridge_ctrl.sv ====
// Our own choice: the strobed register port.
`timescale 1ns/1ns
// How it works
// [RL1] A forward channel sequence error sets a read-only status flag.
// [RL2] Writing one to the clear bit resets the sequence error flag.
// [RL3] SDA output changes are delayed 250ns plus 50ns per delay code step.
// [RL4] With write blocking set, remote writes to local registers are rejected.
// [RL5] Write blocking never restricts remote access to local-side I2C targets.
// [RL6] Bus watchdog expires after one second idle, or 50us when fast.
// [RL7] Enabled watchdog expiring with SDA high marks the bus free.
// [RL8] Watchdog expiring with SDA low drives nine recovery clocks on SCL.
// [RL9] Serializer address sits in bits 7..1 and decodes local transactions.
// [RL10] A zero serializer address forwards nothing to the serializer; first-alias hits are still forwarded.
// [RL11] After receive lock the serializer address loads from its sent identifier.
// [RL12] While hold is set, auto-load is suppressed and the written value kept.
// [RL13] Software writing the serializer address should also set hold.
// [RL14] First remote target physical address sits in bits 7..1.
// [RL15] Transactions to the first alias are remapped to the physical address.
// [RL16] Matching transactions are forwarded only while pass-through is enabled.
// [RL17] The sequence error flag stays set until software clears it.
module i2c_bridge_ctrl #(
  parameter int WD_SLOW_CYC = bridge_pkg::WD_SLOW_CYC,
  parameter int WD_FAST_CYC = bridge_pkg::WD_FAST_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic fwd_seq_err,
  input wire logic rx_lock,
  input wire logic ser_id_valid,
  input wire logic [6:0] ser_id,
  input wire bridge_pkg::rem_acc_t rem_acc,
  output logic rem_accept,
  output logic rem_reject,
  input wire bridge_pkg::loc_addr_t loc_addr,
  output bridge_pkg::fwd_t fwd,
  input wire logic sda_drive_req_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic bus_free
);
  typedef enum logic [1:0] {WD_WATCH, WD_FREE, WD_RECOV} wd_state_t;

  logic [7:0] ctrl_r;
  logic seq_err_r;
  logic [7:0] ser_addr_r;
  logic [7:0] phys0_r;
  logic [7:0] cfg_r;
  logic [7:0] alias0_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic [3:0] ev;
  logic wr_ctrl;
  logic wr_ser;
  logic seq_clr;
  logic scl_m_r, scl_s_r, scl_p_r;
  logic sda_m_r, sda_s_r, sda_p_r;
  logic activity;
  logic wd_enable;
  logic [26:0] wd_limit;
  logic [26:0] idle_cnt_r;
  logic wd_expire;
  wd_state_t wd_state_r;
  logic [9:0] half_cnt_r;
  logic [3:0] pulse_cnt_r;
  logic recov_done;
  logic [5:0] sda_cnt_r;
  logic [5:0] sda_target;
  logic loc_hits_ser;
  logic loc_hits_alias;

  // Cycle count for a given SDA delay code, rounded up
  function automatic logic [5:0] sda_dly_cyc(input logic [1:0] code);
    int ns;
    ns = bridge_pkg::SDA_DLY_BASE_NS + bridge_pkg::SDA_DLY_STEP_NS * int'(code);
    return 6'((ns + bridge_pkg::CLK_PERIOD_NS - 1) / bridge_pkg::CLK_PERIOD_NS);
  endfunction

  // Seven-bit address held in bits 7..1 of a register
  function automatic logic [6:0] addr_field(input logic [7:0] r);
    return r[7:bridge_pkg::ADDR_LSB];
  endfunction

  assign wr_ctrl = reg_wr && (reg_addr == bridge_pkg::OFS_CTRL);
  assign wr_ser = reg_wr && (reg_addr == bridge_pkg::OFS_SER_ADDR);
  assign seq_clr = wr_ctrl && reg_wdata[bridge_pkg::CTRL_SEQ_CLR_BIT];

  // Control register: writable fields, bit 7 read from the error flag, bit 5 always reads zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= bridge_pkg::RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_r <= {2'h0, reg_wdata[5:0]} & 8'h5F;
      ctrl_r[bridge_pkg::CTRL_SEQ_CLR_BIT] <= reg_wdata[bridge_pkg::CTRL_SEQ_CLR_BIT];
    end
  end

  // Sequence error flag: sticky, a new error wins over a clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_err_r <= 1'b0;
    end else if (fwd_seq_err) begin
      seq_err_r <= 1'b1; // [RL1] [RL17]
    end else if (seq_clr) begin
      seq_err_r <= 1'b0; // [RL2]
    end
  end

  // Serializer address: software write first, else auto-load after lock
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_addr_r <= bridge_pkg::RST_SER_ADDR;
    end else if (wr_ser) begin
      ser_addr_r <= reg_wdata; // [RL9]
    end else if (rx_lock && ser_id_valid && !ser_addr_r[bridge_pkg::FREEZE_BIT]) begin // [RL12]
      ser_addr_r[7:bridge_pkg::ADDR_LSB] <= ser_id; // [RL11]
    end
  end

  // Remaining software registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phys0_r <= bridge_pkg::RST_PHYS0;
      cfg_r <= bridge_pkg::RST_CFG;
      alias0_r <= bridge_pkg::RST_ALIAS0;
      irq_mask_r <= bridge_pkg::RST_IRQ_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        bridge_pkg::OFS_PHYS0: phys0_r <= {reg_wdata[7:1], 1'b0}; // [RL14]
        bridge_pkg::OFS_CFG: cfg_r <= {7'h00, reg_wdata[bridge_pkg::CFG_PASS_BIT]};
        bridge_pkg::OFS_ALIAS0: alias0_r <= {reg_wdata[7:1], 1'b0};
        bridge_pkg::OFS_IRQ_MASK: irq_mask_r <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Interrupt status: events set, a read clears, set wins
  assign ev[bridge_pkg::EV_SEQ_ERR] = fwd_seq_err;
  assign ev[bridge_pkg::EV_BUS_FREE] = wd_expire && sda_s_r;
  assign ev[bridge_pkg::EV_BUS_RECOV] = recov_done;
  assign ev[bridge_pkg::EV_WR_REJECT] = rem_acc.valid && rem_acc.write && rem_acc.to_regs
                                        && ctrl_r[bridge_pkg::CTRL_BLOCK_BIT];
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= 4'h0;
    end else if (reg_rd && reg_addr == bridge_pkg::OFS_IRQ_STAT) begin
      irq_stat_r <= ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        bridge_pkg::OFS_CTRL: reg_rdata <= {seq_err_r, ctrl_r[6], 1'b0, ctrl_r[4:0]};
        bridge_pkg::OFS_SER_ADDR: reg_rdata <= ser_addr_r;
        bridge_pkg::OFS_PHYS0: reg_rdata <= phys0_r;
        bridge_pkg::OFS_CFG: reg_rdata <= cfg_r;
        bridge_pkg::OFS_ALIAS0: reg_rdata <= alias0_r;
        bridge_pkg::OFS_IRQ_STAT: reg_rdata <= {4'h0, irq_stat_r};
        bridge_pkg::OFS_IRQ_MASK: reg_rdata <= {4'h0, irq_mask_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Remote accesses from the far controller: block only local register writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rem_accept <= 1'b0;
      rem_reject <= 1'b0;
    end else begin
      rem_reject <= ev[bridge_pkg::EV_WR_REJECT]; // [RL4]
      rem_accept <= rem_acc.valid && !ev[bridge_pkg::EV_WR_REJECT]; // [RL5]
    end
  end

  // Local address decode and remap toward the serializer
  assign loc_hits_ser = (addr_field(ser_addr_r) != 7'h00)
                        && (loc_addr.addr == addr_field(ser_addr_r)); // [RL9] [RL10]
  assign loc_hits_alias = (addr_field(alias0_r) != 7'h00)
                          && (loc_addr.addr == addr_field(alias0_r));
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fwd <= '0;
    end else begin
      fwd.valid <= loc_addr.valid && cfg_r[bridge_pkg::CFG_PASS_BIT]
                   && (loc_hits_ser || loc_hits_alias); // [RL16]
      fwd.remapped <= !loc_hits_ser && loc_hits_alias;
      fwd.addr <= loc_hits_ser ? loc_addr.addr : addr_field(phys0_r); // [RL15]
    end
  end

  // Two-flop synchronisers for the bus pins, plus one more stage for change detect
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
    end
  end
  assign activity = (scl_s_r ^ scl_p_r) | (sda_s_r ^ sda_p_r);

  // Watchdog: count idle cycles while enabled and watching
  assign wd_enable = !ctrl_r[bridge_pkg::CTRL_WD_OFF_BIT];
  assign wd_limit = ctrl_r[bridge_pkg::CTRL_FAST_BIT] ? 27'(WD_FAST_CYC) : 27'(WD_SLOW_CYC); // [RL6]
  assign wd_expire = wd_enable && (wd_state_r == WD_WATCH) && !activity
                     && (idle_cnt_r == wd_limit - 27'h0000001);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt_r <= 27'h0000000;
    end else if (!wd_enable || activity || wd_state_r != WD_WATCH || wd_expire) begin
      idle_cnt_r <= 27'h0000000;
    end else begin
      idle_cnt_r <= idle_cnt_r + 27'h0000001;
    end
  end

  // Watchdog outcome: free bus or clock-out recovery
  assign recov_done = (wd_state_r == WD_RECOV) && (pulse_cnt_r == 4'(bridge_pkg::RECOV_PULSES))
                      && (half_cnt_r == 10'(bridge_pkg::RECOV_HALF_CYC - 1));
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_state_r <= WD_WATCH;
    end else begin
      case (wd_state_r)
        WD_WATCH: begin
          if (wd_expire) begin
            wd_state_r <= sda_s_r ? WD_FREE : WD_RECOV; // [RL7] [RL8]
          end
        end
        WD_FREE: begin
          if (activity || !wd_enable) begin
            wd_state_r <= WD_WATCH;
          end
        end
        WD_RECOV: begin
          if (recov_done) begin
            wd_state_r <= WD_WATCH;
          end
        end
        default: wd_state_r <= WD_WATCH;
      endcase
    end
  end
  assign bus_free = (wd_state_r == WD_FREE);

  // Recovery clocks: low half then high half, nine times
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_cnt_r <= 10'h000;
      pulse_cnt_r <= 4'h0;
      scl_oe_n <= 1'b1;
    end else if (wd_state_r != WD_RECOV) begin
      half_cnt_r <= 10'h000;
      pulse_cnt_r <= 4'h0;
      scl_oe_n <= !(wd_expire && !sda_s_r);
    end else if (half_cnt_r == 10'(bridge_pkg::RECOV_HALF_CYC - 1)) begin
      half_cnt_r <= 10'h000;
      if (!scl_oe_n) begin
        pulse_cnt_r <= pulse_cnt_r + 4'h1; // [RL8]
      end
      scl_oe_n <= !scl_oe_n || (pulse_cnt_r == 4'(bridge_pkg::RECOV_PULSES)); // [RL8] No tenth low half
    end else begin
      half_cnt_r <= half_cnt_r + 10'h001;
    end
  end
  assign scl_out = 1'b0;

  // SDA output delay: a new drive level passes only after standing the full delay
  assign sda_target = sda_dly_cyc(ctrl_r[bridge_pkg::CTRL_DLY_LSB +: 2]);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_cnt_r <= 6'h00;
      sda_oe_n <= 1'b1;
    end else if (sda_drive_req_n == sda_oe_n) begin
      sda_cnt_r <= 6'h00;
    end else if (sda_cnt_r == sda_target - 6'h01) begin
      sda_cnt_r <= 6'h00;
      sda_oe_n <= sda_drive_req_n; // [RL3]
    end else begin
      sda_cnt_r <= sda_cnt_r + 6'h01;
    end
  end
  assign sda_out = 1'b0;

  a_seq_err_set: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL1]
    fwd_seq_err |=> seq_err_r)
    else $error("sequence error not flagged");
  a_seq_err_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL2]
    seq_clr && !fwd_seq_err |=> !seq_err_r && reg_rdata == 8'h00)
    else $error("sequence error not cleared");
  a_seq_err_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL17]
    seq_err_r && !seq_clr |=> seq_err_r)
    else $error("sequence error self cleared");
  a_sda_delay_time: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL3]
    $changed(sda_oe_n) |-> $past(sda_cnt_r) == $past(sda_target) - 6'h01
      && $past(sda_drive_req_n) == sda_oe_n)
    else $error("sda delay wrong");
  a_block_remote_wr: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL4]
    rem_acc.valid && rem_acc.write && rem_acc.to_regs && ctrl_r[bridge_pkg::CTRL_BLOCK_BIT]
      |=> rem_reject && !rem_accept ##1 irq_stat_r[bridge_pkg::EV_WR_REJECT])
    else $error("remote write not blocked");
  a_target_pass: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL5]
    rem_acc.valid && !rem_acc.to_regs |=> rem_accept && !rem_reject)
    else $error("target access blocked");
  a_wd_expire_time: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL6]
    wd_expire |-> idle_cnt_r + 27'h0000001 == (ctrl_r[bridge_pkg::CTRL_FAST_BIT] ? 27'(WD_FAST_CYC) : 27'(WD_SLOW_CYC)))
    else $error("watchdog limit wrong");
  a_bus_free_mark: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL7]
    wd_expire && sda_s_r |=> bus_free && scl_oe_n)
    else $error("bus not marked free");
  a_nine_clocks: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL8]
    recov_done |-> pulse_cnt_r == 4'h9 && scl_oe_n ##1 wd_state_r == WD_WATCH && scl_oe_n)
    else $error("recovery clock count wrong");
  a_zero_no_fwd: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL10]
    fwd.valid && !fwd.remapped |-> $past(ser_addr_r[7:1]) != 7'h00)
    else $error("forward with zero serializer address");
  a_auto_load: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL11]
    rx_lock && ser_id_valid && !ser_addr_r[0] && !wr_ser |=> ser_addr_r[7:1] == $past(ser_id))
    else $error("serializer address not loaded");
  a_hold_addr: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL12]
    ser_addr_r[0] && !wr_ser |=> $stable(ser_addr_r))
    else $error("held serializer address changed");
  a_alias_remap: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL15]
    loc_addr.valid && cfg_r[0] && loc_hits_alias && !loc_hits_ser
      |=> fwd.valid && fwd.remapped && fwd.addr == $past(phys0_r[7:1]))
    else $error("alias not remapped");
  a_pass_gate: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL16]
    fwd.valid |-> $past(cfg_r[0]) && $past(loc_addr.valid))
    else $error("forward without pass-through");
endmodule

// ==== shared/bridge_pkg.sv ====
package bridge_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFS_CTRL = 8'h06;
  localparam logic [7:0] OFS_SER_ADDR = 8'h07;
  localparam logic [7:0] OFS_PHYS0 = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_ALIAS0 = 8'h11;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h12;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h13;
  // Control and status register fields
  localparam int CTRL_SEQ_ERR_BIT = 7;
  localparam int CTRL_SEQ_CLR_BIT = 6;
  localparam int CTRL_DLY_LSB = 3;
  localparam int CTRL_BLOCK_BIT = 2;
  localparam int CTRL_FAST_BIT = 1;
  localparam int CTRL_WD_OFF_BIT = 0;
  localparam int ADDR_LSB = 1;
  localparam int FREEZE_BIT = 0;
  localparam int CFG_PASS_BIT = 0;
  // Interrupt status bits
  localparam int EV_SEQ_ERR = 0;
  localparam int EV_BUS_FREE = 1;
  localparam int EV_BUS_RECOV = 2;
  localparam int EV_WR_REJECT = 3;
  localparam int EV_NUM = 4;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_SER_ADDR = 8'h00;
  localparam logic [7:0] RST_PHYS0 = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_ALIAS0 = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  // Timing
  localparam longint CLK_FREQ_HZ = 125000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WD_SLOW_S = 1;
  localparam int WD_FAST_US = 50;
  localparam int WD_SLOW_CYC = int'(WD_SLOW_S * CLK_FREQ_HZ);
  localparam int WD_FAST_CYC = int'((WD_FAST_US * CLK_FREQ_HZ) / 1000000);
  localparam int SDA_DLY_BASE_NS = 250;
  localparam int SDA_DLY_STEP_NS = 50;
  localparam int RECOV_HALF_NS = 5000;
  localparam int RECOV_HALF_CYC = RECOV_HALF_NS / CLK_PERIOD_NS;
  localparam int RECOV_PULSES = 9;
  // Remote access arriving over the control channel
  typedef struct packed {
    logic valid;
    logic write;
    logic to_regs;
  } rem_acc_t;
  // Local I2C address phase seen by the target logic
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } loc_addr_t;
  // Transaction forwarded to the serializer
  typedef struct packed {
    logic valid;
    logic remapped;
    logic [6:0] addr;
  } fwd_t;
endpackage

// ==== testbench/far_side_model.sv ====
`timescale 1ns/1ns
// Remote serializer and the shared I2C wires seen from the block's pins
module far_side_model #(
  parameter logic [6:0] SER_ID = 7'h35
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic hold_sda_low,
  input wire logic link_up,
  output logic scl_in,
  output logic sda_in,
  output logic rx_lock,
  output logic ser_id_valid,
  output logic [6:0] ser_id
);
  logic sent_r;
  // Open-drain wires with pull-ups; a stuck target may pin SDA low
  assign scl_in = scl_oe_n;
  assign sda_in = sda_oe_n & ~hold_sda_low;
  // Identifier shows only during its strobe, inverted otherwise
  assign ser_id = ser_id_valid ? SER_ID : ~SER_ID;
  // Lock follows the link; one identifier strobe per lock
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_lock <= 1'b0;
      ser_id_valid <= 1'b0;
      sent_r <= 1'b0;
    end else begin
      rx_lock <= link_up;
      ser_id_valid <= link_up & rx_lock & ~sent_r;
      sent_r <= link_up & (sent_r | rx_lock);
    end
  end
endmodule

// ==== testbench/i2c_bridge_ctrl_tb.sv ====
`timescale 1ns/1ns
module i2c_bridge_ctrl_tb;
  localparam int SLOW = 200;
  localparam int FAST = 50;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fwd_seq_err = 1'b0;
  logic sda_drive_req_n = 1'b1;
  logic hold_sda_low = 1'b0;
  logic link_up = 1'b0;
  bridge_pkg::rem_acc_t rem_acc = '0;
  bridge_pkg::loc_addr_t loc_addr = '0;
  bridge_pkg::fwd_t fwd;
  logic [7:0] reg_rdata;
  logic [6:0] ser_id;
  logic irq, rx_lock, ser_id_valid, rem_accept, rem_reject, bus_free;
  logic scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n, prev;
  int failures = 0;
  int cmp_count = 0;
  int n;
  int k;

  i2c_bridge_ctrl #(.WD_SLOW_CYC(SLOW), .WD_FAST_CYC(FAST)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .fwd_seq_err(fwd_seq_err), .rx_lock(rx_lock), .ser_id_valid(ser_id_valid), .ser_id(ser_id),
    .rem_acc(rem_acc), .rem_accept(rem_accept), .rem_reject(rem_reject), .loc_addr(loc_addr), .fwd(fwd),
    .sda_drive_req_n(sda_drive_req_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_free(bus_free));

  far_side_model far (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .hold_sda_low(hold_sda_low), .link_up(link_up), .scl_in(scl_in), .sda_in(sda_in), .rx_lock(rx_lock),
    .ser_id_valid(ser_id_valid), .ser_id(ser_id));

  // Free-running clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read strobe, then the data in the following cycle only
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask

  task automatic rem(input logic [2:0] v, input logic [1:0] e);
    @(posedge ref_clk);
    rem_acc <= v;
    @(posedge ref_clk);
    rem_acc <= {1'b0, ~v[1:0]};
    #1 chk(16'({rem_accept, rem_reject}), 16'(e));
  endtask

  task automatic loc(input logic [6:0] a, input logic [8:0] e);
    @(posedge ref_clk);
    loc_addr <= {1'b1, a};
    @(posedge ref_clk);
    loc_addr <= {1'b0, ~a};
    #1 chk(e[8] ? 16'(fwd) : 16'(fwd.valid), 16'(e));
  endtask

  task automatic wait_for(ref logic s, input logic lvl, output int c);
    c = 0;
    while (s !== lvl && c < 20000) begin
      @(posedge ref_clk);
      #1 c++;
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run length
  initial begin
    #(8 * 60000);
    failures++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rc(8'h06, 8'h00);
    rc(8'h07, 8'h00);
    rc(8'h08, 8'h00);
    rc(8'h3F, 8'h00);
    wr(8'h06, 8'hFF);
    rc(8'h06, 8'h5F);
    wr(8'h08, 8'hFF);
    rc(8'h08, 8'hFE);
    // Sequence error: sticky flag, interrupt and clearing
    wr(8'h13, 8'h0F);
    wr(8'h12, 8'h00);
    rc(8'h12, 8'h00);
    @(posedge ref_clk);
    fwd_seq_err <= 1'b1;
    @(posedge ref_clk);
    fwd_seq_err <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rc(8'h06, 8'hDF);
    chk(16'(irq), 16'h1);
    wr(8'h13, 8'h0E);
    #1 chk(16'(irq), 16'h0);
    wr(8'h13, 8'h0F);
    wr(8'h06, 8'h5F);
    rc(8'h06, 8'h5F);
    rc(8'h12, 8'h01);
    rc(8'h12, 8'h00);
    // Remote accesses against the write block
    rem(3'b111, 2'b01);
    rem(3'b110, 2'b10);
    rem(3'b101, 2'b10);
    rc(8'h12, 8'h08);
    wr(8'h06, 8'h01);
    rem(3'b111, 2'b10);
    // Serializer address auto-load, then a frozen software value
    wr(8'h07, 8'h00);
    link_up <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rc(8'h07, 8'h6A);
    link_up <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wr(8'h07, 8'h45);
    link_up <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rc(8'h07, 8'h45);
    // Address decode and alias remap
    wr(8'h10, 8'h01);
    wr(8'h11, 8'hA0);
    wr(8'h08, 8'h66);
    loc(7'h22, {2'b10, 7'h22});
    loc(7'h50, {2'b11, 7'h33});
    loc(7'h10, 9'h000);
    wr(8'h07, 8'h01);
    loc(7'h00, 9'h000);
    wr(8'h07, 8'h45);
    wr(8'h10, 8'h00);
    loc(7'h22, 9'h000);
    // SDA output delay per code, then a request too short to pass
    for (int c = 0; c < 4; c++) begin
      wr(8'h06, 8'(c << 3) | 8'h01);
      @(posedge ref_clk);
      sda_drive_req_n <= 1'b0;
      wait_for(sda_oe_n, 1'b0, n);
      k = (250 + 50 * c + 7) / 8;
      chk(16'(n >= k && n <= k + 2), 16'h1);
      sda_drive_req_n <= 1'b1;
      repeat (60) @(posedge ref_clk);
    end
    sda_drive_req_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    sda_drive_req_n <= 1'b1;
    repeat (60) @(posedge ref_clk);
    #1 chk(16'(sda_oe_n), 16'h1);
    // Fast watchdog: free bus, then a hung bus and its recovery
    rc(8'h12, 8'h00);
    wr(8'h06, 8'h02);
    wait_for(bus_free, 1'b1, n);
    chk(16'(n >= FAST && n <= FAST + 10), 16'h1);
    rc(8'h12, 8'h02);
    hold_sda_low <= 1'b1;
    wait_for(bus_free, 1'b0, n);
    chk(16'(bus_free), 16'h0);
    k = 0;
    n = 0;
    prev = scl_oe_n;
    while (k < 9 && n < 20000) begin
      @(posedge ref_clk);
      #1 n++;
      if (prev && !scl_oe_n) k++;
      prev = scl_oe_n;
    end
    hold_sda_low <= 1'b0;
    repeat (1500) begin
      @(posedge ref_clk);
      #1 if (prev && !scl_oe_n) k++;
      prev = scl_oe_n;
    end
    chk(16'(k), 16'd9);
    rc(8'h12, 8'h06);
    // Slow watchdog after a disable clears the free state
    wr(8'h06, 8'h01);
    @(posedge ref_clk);
    #1 chk(16'(bus_free), 16'h0);
    chk(16'({scl_out, sda_out}), 16'h0);
    wr(8'h06, 8'h00);
    wait_for(bus_free, 1'b1, n);
    chk(16'(n >= SLOW && n <= SLOW + 10), 16'h1);
    conclude();
  end
endmodule
